// ==== tws_defines.svh ====
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH
`define TWS_ADDR_MODE 16'hff60
`define TWS_ADDR_BUSCTL 16'hff61
`define TWS_ADDR_TIMING 16'hff62
`define TWS_ADDR_SHIFT 16'hff63
`define TWS_ADDR_SLAVE 16'hff64
`define TWS_MODE_RESET 8'h00
`define TWS_BUSCTL_RESET 8'h00
`define TWS_TIMING_RESET 8'h00
`define TWS_SHIFT_RESET 8'h00
`define TWS_SLAVE_RESET 8'h00
`define TWS_MODE_WMASK 8'hbf
`define TWS_BUSCTL_WMASK 8'hfc
`define TWS_TIMING_WMASK 8'hb0
`define TWS_BIT_ENABLE 7
`define TWS_BIT_CMPFLAG 6
`define TWS_BIT_WAKE 5
`define TWS_BIT_MODE_HI 4
`define TWS_BIT_MODE_LO 3
`define TWS_BIT_PINSEL 2
`define TWS_BIT_CLK_HI 1
`define TWS_BIT_CLK_LO 0
`define TWS_BIT_RELEASE 0
`define TWS_BIT_COMMAND 1
`define TWS_BIT_CLKLEVEL 6
`define TWS_LAST_BIT 3'h7
`define TWS_MAX_PRESCALE 3'h7
`define TWS_PEER_HALF 8
`endif

// ==== tws_pkg.sv ====
package tws_pkg;
  typedef enum logic [1:0] {
    tws_three_wire = 2'h0,
    tws_three_wire_alt = 2'h1,
    tws_address_bus_mode = 2'h2,
    tws_two_wire = 2'h3
  } tws_mode_t;

  typedef enum logic [2:0] {
    tws_st_idle = 3'h1,
    tws_st_high = 3'h2,
    tws_st_low = 3'h4
  } tws_state_t;

  function automatic logic [7:0] tws_shift_in(input logic [7:0] word, input logic bit_in);
    tws_shift_in = {word[6:0], bit_in};
  endfunction

  // A level moves only once the second and third stages agree.
  function automatic logic tws_filter(input logic [2:0] sync, input logic prev);
    tws_filter = (sync[1] == sync[2]) ? sync[2] : prev;
  endfunction
endpackage

// ==== tws_bus_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface tws_bus_if;
  logic dev_clk_out;
  logic dev_clk_oe;
  logic peer_clk_out;
  logic peer_clk_oe;
  logic [1:0] dev_data_out;
  logic [1:0] dev_data_oe;
  logic [1:0] peer_data_out;
  logic [1:0] peer_data_oe;
  logic clk_line;
  logic [1:0] data_line;

  // Open-drain wires with a pull-up: any enabled low driver wins.
  assign clk_line = !((dev_clk_oe && !dev_clk_out) || (peer_clk_oe && !peer_clk_out));
  assign data_line = ~((dev_data_oe & ~dev_data_out) | (peer_data_oe & ~peer_data_out));

  modport device (output dev_clk_out, output dev_clk_oe, output dev_data_out, output dev_data_oe,
                  input clk_line, input data_line);
  modport peer (output peer_clk_out, output peer_clk_oe, output peer_data_out, output peer_data_oe,
                input clk_line, input data_line);
endinterface // tws_bus_if
`default_nettype wire

// ==== tws_peer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tws_defines.svh"
module tws_peer
  import tws_pkg::*;
#(
  parameter bit DRIVE_CLOCK = 1'b1,
  parameter int HALF_CYCLES = `TWS_PEER_HALF,
  parameter int PIN = 0
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  tws_bus_if.peer bus,
  input wire logic start_in,
  input wire logic receive_in,
  input wire logic [7:0] tx_data_in,
  output logic [7:0] rx_data_out,
  output logic done_out,
  output logic busy_out
);
  initial begin
    if (HALF_CYCLES < 4 || HALF_CYCLES > 255 || PIN < 0 || PIN > 1) begin
      $error("tws_peer: unsupported parameter value");
    end
  end

  logic [2:0] clk_sync_reg;
  logic [2:0] data_sync_reg;
  logic clk_flt_reg;
  logic clk_prev_reg;
  logic data_flt_reg;
  logic [7:0] half_cnt_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic out_latch_reg;
  logic clk_low_reg;
  logic data_low_reg;
  tws_state_t state_reg;
  logic tick;
  logic ev_fall;
  logic ev_rise;
  logic start;

  assign tick = (half_cnt_reg == 8'(HALF_CYCLES - 1));
  assign ev_fall = (state_reg == tws_st_high) && (DRIVE_CLOCK ? tick : (clk_prev_reg && !clk_flt_reg));
  assign ev_rise = (state_reg == tws_st_low) && (DRIVE_CLOCK ? tick : (!clk_prev_reg && clk_flt_reg));
  assign start = start_in && (state_reg == tws_st_idle) && (DRIVE_CLOCK || clk_flt_reg);

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clk_sync_reg <= 3'h7;
      data_sync_reg <= 3'h7;
      clk_flt_reg <= 1'b1;
      clk_prev_reg <= 1'b1;
      data_flt_reg <= 1'b1;
    end else begin
      clk_sync_reg <= {clk_sync_reg[1:0], bus.clk_line};
      data_sync_reg <= {data_sync_reg[1:0], bus.data_line[PIN]};
      clk_flt_reg <= tws_filter(clk_sync_reg, clk_flt_reg);
      clk_prev_reg <= clk_flt_reg;
      data_flt_reg <= tws_filter(data_sync_reg, data_flt_reg);
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      half_cnt_reg <= 8'h00;
    end else if (start || tick || state_reg == tws_st_idle) begin
      half_cnt_reg <= 8'h00;
    end else begin
      half_cnt_reg <= half_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= tws_st_idle;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'hff;
      out_latch_reg <= 1'b1;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      unique case (state_reg)
        tws_st_idle: begin
          if (start) begin
            // A receiving peer loads all ones so its open drain stays released.
            shift_reg <= receive_in ? 8'hff : tx_data_in;
            bit_cnt_reg <= 3'h0;
            state_reg <= tws_st_high;
          end
        end
        tws_st_high: begin
          if (ev_fall) begin
            out_latch_reg <= shift_reg[7];
            state_reg <= tws_st_low;
          end
        end
        tws_st_low: begin
          if (ev_rise) begin
            shift_reg <= tws_shift_in(shift_reg, data_flt_reg);
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == `TWS_LAST_BIT) begin
              state_reg <= tws_st_idle;
              out_latch_reg <= 1'b1;
              done_out <= 1'b1;
            end else begin
              state_reg <= tws_st_high;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clk_low_reg <= 1'b0;
      data_low_reg <= 1'b0;
      busy_out <= 1'b0;
      rx_data_out <= 8'h00;
    end else begin
      clk_low_reg <= DRIVE_CLOCK && (state_reg == tws_st_low);
      data_low_reg <= !out_latch_reg;
      busy_out <= (state_reg != tws_st_idle);
      rx_data_out <= shift_reg;
    end
  end

  assign bus.peer_clk_out = 1'b0;
  assign bus.peer_clk_oe = clk_low_reg;
  assign bus.peer_data_out = 2'h0;
  assign bus.peer_data_oe = (PIN == 1) ? {data_low_reg, 1'b0} : {1'b0, data_low_reg};
endmodule // tws_peer
`default_nettype wire

// ==== tws_channel.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tws_defines.svh"
module tws_channel
  import tws_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  tws_bus_if.device bus,
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic timer_two_output_in,
  input wire logic [3:0] timer_clock_select_three_in,
  input wire logic clock_port_latch_in,
  input wire logic flag_clear_in,
  output logic transfer_end_flag_out,
  output logic busy_out
);
  logic [7:0] mode_reg;
  logic [7:0] busctl_reg;
  logic [7:0] timing_reg;
  logic [7:0] shift_reg;
  logic [7:0] slave_reg;
  logic [2:0] clk_sync_reg;
  logic [2:0] data_sync_reg;
  logic clk_flt_reg;
  logic clk_prev_reg;
  logic data_flt_reg;
  logic [7:0] div_cnt_reg;
  logic [2:0] bit_cnt_reg;
  logic out_latch_reg;
  logic clk_low_reg;
  logic [1:0] data_low_reg;
  tws_state_t state_reg;
  logic [7:0] rdata_next;
  logic enable;
  logic two_wire;
  logic int_clk;
  logic use_timer;
  logic [2:0] pre_sel;
  logic [7:0] pre_mask;
  logic tick;
  logic ev_fall;
  logic ev_rise;
  logic shift_wr;
  logic start;
  logic last;
  logic match;

  assign enable = mode_reg[`TWS_BIT_ENABLE];
  assign two_wire = (tws_mode_t'(mode_reg[`TWS_BIT_MODE_HI:`TWS_BIT_MODE_LO]) == tws_two_wire);
  assign int_clk = mode_reg[`TWS_BIT_CLK_HI];
  assign use_timer = !mode_reg[`TWS_BIT_CLK_LO];
  assign pre_sel = timer_clock_select_three_in[3] ? `TWS_MAX_PRESCALE : timer_clock_select_three_in[2:0];
  assign pre_mask = (8'h01 << pre_sel) - 8'h01;
  // Each tick is one half period, so code n gives a shift clock of the core rate over 2 to the n+1.
  assign tick = use_timer ? timer_two_output_in : ((div_cnt_reg & pre_mask) == pre_mask);
  assign ev_fall = (state_reg == tws_st_high) && (int_clk ? tick : (clk_prev_reg && !clk_flt_reg));
  assign ev_rise = (state_reg == tws_st_low) && (int_clk ? tick : (!clk_prev_reg && clk_flt_reg));
  assign last = ev_rise && (bit_cnt_reg == `TWS_LAST_BIT);
  assign shift_wr = reg_wr_in && (reg_addr_in == `TWS_ADDR_SHIFT);
  // The enable is tested only at the write, so a word loaded while stopped stays parked.
  assign start = shift_wr && enable && two_wire && (state_reg == tws_st_idle) && (int_clk || clk_flt_reg);
  assign match = (slave_reg == shift_reg);

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clk_sync_reg <= 3'h7;
      data_sync_reg <= 3'h7;
      clk_flt_reg <= 1'b1;
      clk_prev_reg <= 1'b1;
      data_flt_reg <= 1'b1;
    end else begin
      clk_sync_reg <= {clk_sync_reg[1:0], bus.clk_line};
      data_sync_reg <= {data_sync_reg[1:0], bus.data_line[mode_reg[`TWS_BIT_PINSEL]]};
      clk_flt_reg <= tws_filter(clk_sync_reg, clk_flt_reg);
      clk_prev_reg <= clk_flt_reg;
      data_flt_reg <= tws_filter(data_sync_reg, data_flt_reg);
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_cnt_reg <= 8'h00;
    end else if (start || tick) begin
      div_cnt_reg <= 8'h00;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_reg <= `TWS_MODE_RESET;
      busctl_reg <= `TWS_BUSCTL_RESET;
      timing_reg <= `TWS_TIMING_RESET;
      slave_reg <= `TWS_SLAVE_RESET;
    end else if (reg_wr_in) begin
      // The compare flag and clock level bits are never stored, so writes cannot touch them.
      if (reg_addr_in == `TWS_ADDR_MODE) begin
        mode_reg <= reg_wdata_in & `TWS_MODE_WMASK;
      end
      if (reg_addr_in == `TWS_ADDR_BUSCTL) begin
        busctl_reg <= reg_wdata_in & `TWS_BUSCTL_WMASK;
      end
      // Low timing bits are not stored; software is expected to write them as zero anyway.
      if (reg_addr_in == `TWS_ADDR_TIMING) begin
        timing_reg <= reg_wdata_in & `TWS_TIMING_WMASK;
      end
      if (reg_addr_in == `TWS_ADDR_SLAVE) begin
        slave_reg <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= tws_st_idle;
      bit_cnt_reg <= 3'h0;
      shift_reg <= `TWS_SHIFT_RESET;
    end else if (!enable) begin
      state_reg <= tws_st_idle;
      if (shift_wr) begin
        shift_reg <= reg_wdata_in;
      end
    end else begin
      unique case (state_reg)
        tws_st_idle: begin
          if (shift_wr) begin
            shift_reg <= reg_wdata_in;
          end
          if (start) begin
            bit_cnt_reg <= 3'h0;
            state_reg <= tws_st_high;
          end
        end
        tws_st_high: begin
          if (ev_fall) begin
            state_reg <= tws_st_low;
          end
        end
        tws_st_low: begin
          if (ev_rise) begin
            // The bus level is taken even while sending, so a lost bit shows in the word.
            shift_reg <= tws_shift_in(shift_reg, data_flt_reg);
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            state_reg <= last ? tws_st_idle : tws_st_high;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      out_latch_reg <= 1'b0;
    end else if (ev_fall) begin
      out_latch_reg <= shift_reg[7];
    end else if (reg_wr_in && (reg_addr_in == `TWS_ADDR_BUSCTL) && (state_reg == tws_st_idle)) begin
      // Triggers are ignored mid-word so a stray write cannot corrupt a bit on the wire.
      if (reg_wdata_in[`TWS_BIT_RELEASE]) begin
        out_latch_reg <= 1'b1;
      end else if (reg_wdata_in[`TWS_BIT_COMMAND]) begin
        out_latch_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      transfer_end_flag_out <= 1'b0;
    end else if (last && (!mode_reg[`TWS_BIT_WAKE] || slave_reg == tws_shift_in(shift_reg, data_flt_reg))) begin
      // The wake bit is honoured as written; keeping it clear in this mode is up to software.
      transfer_end_flag_out <= 1'b1;
    end else if (flag_clear_in) begin
      transfer_end_flag_out <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clk_low_reg <= 1'b0;
      data_low_reg <= 2'h0;
      busy_out <= 1'b0;
    end else begin
      clk_low_reg <= enable && two_wire && int_clk &&
                     ((state_reg == tws_st_low) || (state_reg == tws_st_idle && !clock_port_latch_in));
      data_low_reg <= {2{enable && two_wire && !out_latch_reg}} &
                      (mode_reg[`TWS_BIT_PINSEL] ? 2'h2 : 2'h1);
      busy_out <= (state_reg != tws_st_idle);
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    unique case (reg_addr_in)
      `TWS_ADDR_MODE: begin
        rdata_next = mode_reg;
        rdata_next[`TWS_BIT_CMPFLAG] = enable && match;
      end
      `TWS_ADDR_BUSCTL: rdata_next = busctl_reg;
      `TWS_ADDR_TIMING: begin
        rdata_next = timing_reg;
        rdata_next[`TWS_BIT_CLKLEVEL] = enable && clk_flt_reg;
      end
      `TWS_ADDR_SHIFT: rdata_next = shift_reg;
      `TWS_ADDR_SLAVE: rdata_next = slave_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= rdata_next;
    end
  end

  assign bus.dev_clk_out = 1'b0;
  assign bus.dev_clk_oe = clk_low_reg;
  assign bus.dev_data_out = 2'h0;
  assign bus.dev_data_oe = data_low_reg;
endmodule // tws_channel
`default_nettype wire

// ==== tws_link_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module tws_link_chk (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic dev_clk_out,
  input wire logic dev_clk_oe,
  input wire logic [1:0] dev_data_out,
  input wire logic [1:0] dev_data_oe,
  input wire logic clock_port_latch_in,
  input wire logic flag_clear_in,
  input wire logic transfer_end_flag_out,
  input wire logic busy_out
);
  logic clk_oe_q;
  logic [3:0] fall_cnt;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clk_oe_q <= 1'b0;
    end else begin
      clk_oe_q <= dev_clk_oe;
    end
  end
  // Counts clock pulls within one word, so a word cut short or run long shows at its end.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fall_cnt <= 4'h0;
    end else if (!busy_out) begin
      fall_cnt <= 4'h0;
    end else if (dev_clk_oe && !clk_oe_q) begin
      fall_cnt <= fall_cnt + 4'h1;
    end
  end
  property p_open_drain;
    dev_clk_out == 1'b0 && dev_data_out == 2'h0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain line driven high");
  property p_data_low_phase;
    busy_out && $changed(dev_data_oe) |-> dev_clk_oe;
  endproperty
  a_data_low_phase: assert property (p_data_low_phase) else $error("data moved with clock high");
  // The flag is set at the last sample while busy lags the state by one cycle, so busy drops one cycle later.
  property p_flag_at_end;
    $rose(transfer_end_flag_out) |=> $fell(busy_out);
  endproperty
  a_flag_at_end: assert property (p_flag_at_end) else $error("end flag not at word end");
  property p_flag_sticky;
    transfer_end_flag_out && !flag_clear_in |=> transfer_end_flag_out;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("end flag dropped by itself");
  property p_eight_falls;
    $fell(busy_out) |-> fall_cnt == 4'h8;
  endproperty
  a_eight_falls: assert property (p_eight_falls) else $error("word did not have eight clocks");
  property p_cnt_max;
    fall_cnt <= 4'h8;
  endproperty
  a_cnt_max: assert property (p_cnt_max) else $error("more than eight clocks in a word");
  property p_clk_idle;
    $rose(dev_clk_oe) |-> busy_out || !$past(clock_port_latch_in);
  endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("idle clock pulled against port latch");
  property p_clk_half;
    busy_out && $rose(dev_clk_oe) |-> ##[1:300] !dev_clk_oe;
  endproperty
  a_clk_half: assert property (p_clk_half) else $error("clock low phase too long");
  cover property ($rose(transfer_end_flag_out));
  cover property ($fell(busy_out) && fall_cnt == 4'h8);
  cover property ($rose(dev_clk_oe) && !busy_out);
endmodule // tws_link_chk
`default_nettype wire

// ==== test_two_wire_serial_io_channel.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tws_defines.svh"
module test_two_wire_serial_io_channel;
  typedef struct packed {logic [15:0] addr; logic [7:0] wdata; logic [7:0] exp;} tws_row_t;
  // Timing writes keep the low four bits at zero, as software must.
  tws_row_t rows [6] = '{'{`TWS_ADDR_SLAVE, 8'h5a, 8'h5a}, '{`TWS_ADDR_TIMING, 8'hf0, 8'hb0},
    '{`TWS_ADDR_BUSCTL, 8'hff, 8'hfc}, '{`TWS_ADDR_SHIFT, 8'h5a, 8'h5a},
    '{`TWS_ADDR_MODE, 8'h7f, 8'h3f}, '{16'hff70, 8'h12, 8'h00}};
  logic [7:0] modes [2] = '{8'h83, 8'h93};
  logic core_clk, arst_n, reg_wr, flag_clr, clk_latch, peer_start, peer_rcv, flag, busy;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, peer_tx, peer_rx, wire_word;
  logic [3:0] tmr_cnt;
  logic tmr_tick;
  int err_total, cmp_count;
  tws_bus_if bus_a();
  tws_channel tws_channel_inst (.core_clk_in(core_clk), .arst_n_in(arst_n), .bus(bus_a.device),
    .reg_wr_in(reg_wr), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
    .timer_two_output_in(tmr_tick), .timer_clock_select_three_in(4'h4), .clock_port_latch_in(clk_latch),
    .flag_clear_in(flag_clr), .transfer_end_flag_out(flag), .busy_out(busy));
  tws_peer #(.DRIVE_CLOCK(1'b0), .HALF_CYCLES(8), .PIN(0)) tws_peer_inst (.core_clk_in(core_clk),
    .arst_n_in(arst_n), .bus(bus_a.peer), .start_in(peer_start), .receive_in(peer_rcv),
    .tx_data_in(peer_tx), .rx_data_out(peer_rx), .done_out(), .busy_out());
  tws_link_chk tws_link_chk_inst (.core_clk_in(core_clk), .arst_n_in(arst_n),
    .dev_clk_out(bus_a.dev_clk_out), .dev_clk_oe(bus_a.dev_clk_oe), .dev_data_out(bus_a.dev_data_out),
    .dev_data_oe(bus_a.dev_data_oe), .clock_port_latch_in(clk_latch), .flag_clear_in(flag_clr),
    .transfer_end_flag_out(flag), .busy_out(busy));
  // Bits as they appear on the wire at each rising clock; eight rises leave the whole word here.
  always @(posedge bus_a.clk_line) begin
    wire_word <= {wire_word[6:0], bus_a.data_line[0]};
  end
  // A half period of 16 cycles leaves room for the synchroniser lag on both ends before each sample.
  always @(posedge core_clk) begin
    tmr_cnt <= #1 tmr_cnt + 4'h1;
  end
  assign tmr_tick = (tmr_cnt == 4'hf);
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
    reg_addr = a;
    step(2);
    chk(reg_rdata, exp);
  endtask
  task automatic peer_go(input logic rcv, input logic [7:0] d);
    peer_rcv = rcv;
    peer_tx = d;
    peer_start = 1'b1;
    step(1);
    peer_start = 1'b0;
  endtask
  task automatic wait_flag();
    int n;
    n = 0;
    while (flag !== 1'b1 && n < 3000) begin
      step(1);
      n++;
    end
    if (n == 3000) begin
      err_total++;
      $display("MISMATCH t=%0t seen=0 exp=1", $time);
      end_of_test();
    end
    step(10);
  endtask
  task automatic reset_chk();
    rdchk(`TWS_ADDR_MODE, 8'h00);
    rdchk(`TWS_ADDR_BUSCTL, 8'h00);
    rdchk(`TWS_ADDR_TIMING, 8'h00);
    $display("reset test done");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    flag_clr = 1'b0;
    clk_latch = 1'b1;
    peer_start = 1'b0;
    peer_rcv = 1'b1;
    peer_tx = 8'h00;
    tmr_cnt = 4'h0;
    err_total = 0;
    cmp_count = 0;
    step(2);
    arst_n = 1'b1;
    step(4);
    reset_chk();
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rdchk(rows[i].addr, rows[i].exp);
    end
    $display("register table test done");
    foreach (modes[i]) begin
      wr(`TWS_ADDR_MODE, modes[i]);
      wr(`TWS_ADDR_SHIFT, 8'h5a);
      step(40);
      chk({7'h00, busy}, 8'h00);
    end
    wr(`TWS_ADDR_MODE, 8'h00);
    wr(`TWS_ADDR_SHIFT, 8'h5a);
    // The wake bit stays clear in every mode word written after the register table test.
    wr(`TWS_ADDR_MODE, 8'h9b);
    step(40);
    chk({7'h00, busy}, 8'h00);
    rdchk(`TWS_ADDR_MODE, 8'hdb);
    rdchk(`TWS_ADDR_TIMING, 8'hf0);
    $display("enable test done");
    wr(`TWS_ADDR_BUSCTL, 8'h01);
    peer_go(1'b1, 8'hff);
    wr(`TWS_ADDR_SHIFT, 8'ha5);
    step(3);
    chk({7'h00, busy}, 8'h01);
    wait_flag();
    chk({7'h00, flag}, 8'h01);
    chk(wire_word, 8'ha5);
    chk(peer_rx, 8'ha5);
    rdchk(`TWS_ADDR_SHIFT, 8'ha5);
    rdchk(`TWS_ADDR_MODE, 8'h9b);
    flag_clr = 1'b1;
    step(1);
    flag_clr = 1'b0;
    step(1);
    chk({7'h00, flag}, 8'h00);
    $display("transmit test done");
    wr(`TWS_ADDR_SLAVE, 8'h3c);
    peer_go(1'b0, 8'h3c);
    wr(`TWS_ADDR_SHIFT, 8'hff);
    step(30);
    wr(`TWS_ADDR_SHIFT, 8'h00);
    wait_flag();
    rdchk(`TWS_ADDR_SHIFT, 8'h3c);
    chk(wire_word, 8'h3c);
    rdchk(`TWS_ADDR_MODE, 8'hdb);
    $display("receive test done");
    wr(`TWS_ADDR_BUSCTL, 8'h02);
    step(3);
    chk({7'h00, bus_a.data_line[0]}, 8'h00);
    wr(`TWS_ADDR_BUSCTL, 8'h01);
    step(3);
    chk({7'h00, bus_a.data_line[0]}, 8'h01);
    clk_latch = 1'b0;
    step(4);
    chk({7'h00, bus_a.clk_line}, 8'h00);
    clk_latch = 1'b1;
    step(4);
    chk({7'h00, bus_a.clk_line}, 8'h01);
    $display("pin control test done");
    flag_clr = 1'b1;
    step(1);
    flag_clr = 1'b0;
    wr(`TWS_ADDR_MODE, 8'h9a);
    peer_go(1'b1, 8'hff);
    wr(`TWS_ADDR_SHIFT, 8'h96);
    wait_flag();
    chk({7'h00, flag}, 8'h01);
    chk(peer_rx, 8'h96);
    rdchk(`TWS_ADDR_SHIFT, 8'h96);
    $display("timer clock test done");
    arst_n = 1'b0;
    step(2);
    arst_n = 1'b1;
    step(4);
    reset_chk();
    end_of_test();
  end
endmodule // test_two_wire_serial_io_channel
`default_nettype wire
